/* File: hw/msgq_pkg.sv */
// Constants and types shared by both ends of the configuration link.
// Assumes a single clock; fields follow the second half of the config message.
package msgq_pkg;
	localparam logic [7:0] MODE_LINK = 8'h00;
	localparam logic [7:0] MODE_FE_HOST = 8'h01;
	localparam logic [7:0] MODE_FE_NET = 8'h02;
	localparam logic [7:0] KEEP8 = 8'hFF;
	localparam logic [31:0] KEEP_PLACE = 32'hFFFF_FFFF;
	localparam logic [7:0] RST_PROCS = 8'h0C;
	localparam logic [7:0] RST_MBOXES = 8'h10;
	localparam logic [7:0] RST_SLOTS = 8'h08;
	localparam logic [7:0] RST_HOSTS = 8'h00;
	localparam logic [7:0] MAX_PROCS = 8'h80;
	localparam logic [7:0] MAX_MBOXES = 8'h80;
	localparam logic [7:0] MAX_SLOTS = 8'hFC;
	localparam logic [16:0] WIN_LO_START = 17'h00200;
	localparam logic [16:0] WIN_LO_END = 17'h003FF;
	localparam logic [16:0] WIN_HI_START = 17'h01000;
	localparam logic [16:0] WIN_HI_END = 17'h0FFFF;
	localparam logic [31:0] DEF_PLACE = 32'h0000_2000;
	localparam logic [16:0] DEF_BLOCK_SIZE = 17'h00100;
	localparam logic [7:0] RC_OK = 8'h00;
	localparam logic [7:0] RC_FORMAT = 8'hA7;
	localparam logic [7:0] RC_PLACE = 8'hA8;
	localparam logic [7:0] RC_PROCS = 8'hA9;
	localparam logic [7:0] RC_MBOXES = 8'hAA;
	localparam logic [7:0] RC_SLOTS = 8'hAB;
	localparam logic [7:0] RC_HOSTS = 8'hAC;
	localparam logic [7:0] RC_QUEUE = 8'hAD;
	localparam logic [7:0] NT_NONE = 8'h00;
	localparam logic [7:0] NT_MEMWR = 8'h02;
	localparam logic [7:0] NT_VECT = 8'h04;
	localparam int AM_LSB = 24;
	localparam int AM_W = 6;
	localparam logic [31:0] BASE_RSV_MASK = 32'hC000_0000;
	localparam logic [31:0] BASE_ALIGN_MASK = 32'h0000_000F;
	localparam logic [15:0] BUF_LINK_OFF = 16'h0000;
	localparam logic [15:0] BUF_RSV_OFF = 16'h0002;
	localparam logic [15:0] BUF_STAT_OFF = 16'h0003;
	localparam logic [15:0] BUF_LEN_OFF = 16'h0004;
	localparam logic [15:0] BUF_DATA_OFF = 16'h0006;
	localparam int STAT_OWNER_BIT = 0;
	localparam int RING_IN = 0;
	localparam int RING_OUT = 1;
	// Host-side register word offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PLACE = 8'h04;
	localparam logic [7:0] REG_COUNTS = 8'h08;
	localparam logic [7:0] REG_IN_BASE = 8'h0C;
	localparam logic [7:0] REG_IN_NOTE = 8'h10;
	localparam logic [7:0] REG_IN_NADDR = 8'h14;
	localparam logic [7:0] REG_OUT_BASE = 8'h18;
	localparam logic [7:0] REG_OUT_NOTE = 8'h1C;
	localparam logic [7:0] REG_OUT_NADDR = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_RPLACE = 8'h28;
	localparam logic [7:0] REG_RCOUNTS = 8'h2C;
	localparam logic [7:0] REG_EVENTS = 8'h30;

	typedef struct packed {
		logic [31:0] base;
		logic [15:0] hdr;
		logic [7:0] ntype;
		logic [7:0] nval;
		logic [31:0] naddr;
	} ring_cfg_t;

	typedef struct packed {
		logic [7:0] mode;
		logic [31:0] place;
		logic [7:0] procs;
		logic [7:0] mboxes;
		logic [7:0] slots;
		logic [7:0] hosts;
		ring_cfg_t [1:0] ring;
	} cfg_msg_t;

	function automatic logic [23:0] ring_addr(input logic [31:0] base, input logic [15:0] off);
		ring_addr = base[23:0] + {8'h00, off};
	endfunction : ring_addr

	function automatic logic ring_ok(input ring_cfg_t r);
		ring_ok = ((r.base & (BASE_RSV_MASK | BASE_ALIGN_MASK)) == 32'h0000_0000) &&
			(r.ntype == NT_NONE || r.ntype == NT_MEMWR || r.ntype == NT_VECT);
	endfunction : ring_ok
endpackage : msgq_pkg

/* File: hw/cfg_link_if.sv */
// Link between the board end and the host end: config request, reply, notices.
// Both ends share one clock; every strobe is a one-cycle pulse.
`timescale 1ns/1ps
interface cfg_link_if;
	logic req_valid;
	msgq_pkg::cfg_msg_t req;
	logic rsp_valid;
	logic [7:0] rsp_code;
	msgq_pkg::cfg_msg_t rsp;
	logic note_wr;
	logic note_irq;
	logic note_ring;
	logic [23:0] note_addr;
	logic [5:0] note_am;
	logic [7:0] note_data;
	logic [15:0] note_vec;

	modport dev(
		input req_valid, req,
		output rsp_valid, rsp_code, rsp,
		output note_wr, note_irq, note_ring, note_addr, note_am, note_data, note_vec
	);
	modport host(
		output req_valid, req,
		input rsp_valid, rsp_code, rsp,
		input note_wr, note_irq, note_ring, note_addr, note_am, note_data, note_vec
	);
endinterface : cfg_link_if

/* File: hw/msgq_dev_end.sv */
// Board end: checks and applies the config request, answers one cycle later,
// and raises host notices for the two message rings.
// Assumes the host end holds req stable at least in the cycle of req_valid.
`timescale 1ns/1ps
module msgq_dev_end #(
	parameter logic [31:0] DEFAULT_PLACE = msgq_pkg::DEF_PLACE,
	parameter logic [16:0] BLOCK_SIZE = msgq_pkg::DEF_BLOCK_SIZE
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	cfg_link_if.dev LINK,
	input wire logic [1:0] RING_EVENT,
	input wire logic BUF_RING,
	input wire logic [15:0] BUF_OFF,
	input wire logic [7:0] BUF_STATUS_BYTE,
	output logic CONFIGURED,
	output logic QUEUES_ON,
	output logic [7:0] CUR_MODE,
	output logic [31:0] DATA_PLACE,
	output logic [7:0] CUR_PROCS,
	output logic [7:0] CUR_MBOXES,
	output logic [7:0] CUR_SLOTS,
	output logic [7:0] CUR_HOSTS,
	output logic [23:0] INBOUND_HDR_ADDR,
	output logic [23:0] OUTBOUND_HDR_ADDR,
	output logic [23:0] BUF_LINK_ADDR,
	output logic [23:0] BUF_STATUS_ADDR,
	output logic [23:0] BUF_LEN_ADDR,
	output logic [23:0] BUF_DATA_ADDR,
	output logic BUF_DEV_OWNED
);
	msgq_pkg::ring_cfg_t [1:0] ring;
	logic [7:0] code;
	logic fe;
	logic q_on;
	logic [7:0] eff_hosts;
	logic [16:0] blk_end;
	logic in_win;
	logic [31:0] next_place;
	logic [7:0] next_procs;
	logic [7:0] next_mboxes;
	logic [7:0] next_slots;
	logic [1:0] pend;
	logic [1:0] serve;
	msgq_pkg::ring_cfg_t sr;

	always_comb begin
		fe = (LINK.req.mode == msgq_pkg::MODE_FE_HOST) ||
			(LINK.req.mode == msgq_pkg::MODE_FE_NET);
		blk_end = {1'b0, LINK.req.place[15:0]} + BLOCK_SIZE - 17'h00001;
		in_win = (({1'b0, LINK.req.place[15:0]} >= msgq_pkg::WIN_LO_START) &&
			(blk_end <= msgq_pkg::WIN_LO_END)) ||
			(({1'b0, LINK.req.place[15:0]} >= msgq_pkg::WIN_HI_START) &&
			(blk_end <= msgq_pkg::WIN_HI_END) && (blk_end >= msgq_pkg::WIN_HI_START));
		eff_hosts = (LINK.req.hosts == msgq_pkg::KEEP8) ? CUR_HOSTS : LINK.req.hosts;
		q_on = !((LINK.req.mode == msgq_pkg::MODE_FE_NET) && (eff_hosts == 8'h00));
		code = msgq_pkg::RC_OK;
		if (!fe && LINK.req.mode != msgq_pkg::MODE_LINK) begin
			code = msgq_pkg::RC_FORMAT;
		end
		if (code == msgq_pkg::RC_OK && LINK.req.place != msgq_pkg::KEEP_PLACE) begin
			if (!fe || LINK.req.place[31:16] != 16'h0000 || !in_win) begin
				code = msgq_pkg::RC_PLACE;
			end
		end
		if (code == msgq_pkg::RC_OK && LINK.req.procs != msgq_pkg::KEEP8) begin
			if (!fe || LINK.req.procs == 8'h00 || LINK.req.procs > msgq_pkg::MAX_PROCS) begin
				code = msgq_pkg::RC_PROCS;
			end
		end
		if (code == msgq_pkg::RC_OK && LINK.req.mboxes != msgq_pkg::KEEP8) begin
			if (!fe || LINK.req.mboxes == 8'h00 || LINK.req.mboxes > msgq_pkg::MAX_MBOXES) begin
				code = msgq_pkg::RC_MBOXES;
			end
		end
		if (code == msgq_pkg::RC_OK && LINK.req.slots != msgq_pkg::KEEP8 &&
			LINK.req.slots > msgq_pkg::MAX_SLOTS) begin
			code = msgq_pkg::RC_SLOTS;
		end
		if (code == msgq_pkg::RC_OK && LINK.req.hosts != msgq_pkg::KEEP8) begin
			if ((LINK.req.mode == msgq_pkg::MODE_FE_NET) ? (LINK.req.hosts > 8'h01)
				: (LINK.req.hosts != 8'h01)) begin
				code = msgq_pkg::RC_HOSTS;
			end
		end
		// Queue fields are not even looked at when the rings are absent
		if (code == msgq_pkg::RC_OK && q_on) begin
			if (!msgq_pkg::ring_ok(LINK.req.ring[msgq_pkg::RING_IN]) ||
				!msgq_pkg::ring_ok(LINK.req.ring[msgq_pkg::RING_OUT])) begin
				code = msgq_pkg::RC_QUEUE;
			end
		end
	end

	always_comb begin
		next_place = DATA_PLACE;
		next_procs = CUR_PROCS;
		next_mboxes = CUR_MBOXES;
		next_slots = CUR_SLOTS;
		if (code == msgq_pkg::RC_OK && fe) begin
			if (LINK.req.place == msgq_pkg::KEEP_PLACE) begin
				next_place = DEFAULT_PLACE;
			end else begin
				next_place = LINK.req.place;
			end
			if (LINK.req.procs != msgq_pkg::KEEP8) begin
				next_procs = LINK.req.procs;
			end
			if (LINK.req.mboxes != msgq_pkg::KEEP8) begin
				next_mboxes = LINK.req.mboxes;
			end
		end
		if (code == msgq_pkg::RC_OK && LINK.req.slots != msgq_pkg::KEEP8) begin
			next_slots = LINK.req.slots;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CONFIGURED <= 1'b0;
			QUEUES_ON <= 1'b0;
			CUR_MODE <= msgq_pkg::MODE_LINK;
			DATA_PLACE <= DEFAULT_PLACE;
			CUR_PROCS <= msgq_pkg::RST_PROCS;
			CUR_MBOXES <= msgq_pkg::RST_MBOXES;
			CUR_SLOTS <= msgq_pkg::RST_SLOTS;
			CUR_HOSTS <= msgq_pkg::RST_HOSTS;
			ring <= '0;
		end else if (LINK.req_valid && code == msgq_pkg::RC_OK) begin
			CONFIGURED <= 1'b1;
			QUEUES_ON <= q_on;
			CUR_MODE <= LINK.req.mode;
			DATA_PLACE <= next_place;
			CUR_PROCS <= next_procs;
			CUR_MBOXES <= next_mboxes;
			CUR_SLOTS <= next_slots;
			CUR_HOSTS <= eff_hosts;
			if (q_on) begin
				ring <= LINK.req.ring;
			end
		end
	end

	// Reply one cycle after the request; place, procs, mboxes and slots keep old state on refusal, mode, hosts and rings echo the request
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.rsp_valid <= 1'b0;
			LINK.rsp_code <= msgq_pkg::RC_OK;
			LINK.rsp <= '0;
		end else begin
			LINK.rsp_valid <= LINK.req_valid;
			if (LINK.req_valid) begin
				LINK.rsp_code <= code;
				LINK.rsp.mode <= LINK.req.mode;
				LINK.rsp.place <= next_place;
				LINK.rsp.procs <= next_procs;
				LINK.rsp.mboxes <= next_mboxes;
				LINK.rsp.slots <= next_slots;
				LINK.rsp.hosts <= LINK.req.hosts;
				LINK.rsp.ring <= LINK.req.ring;
			end
		end
	end

	// Ring notices: pending per ring, inbound served first
	assign serve = pend[msgq_pkg::RING_IN] ? 2'b01 : {pend[msgq_pkg::RING_OUT], 1'b0};
	assign sr = serve[msgq_pkg::RING_OUT] ? ring[msgq_pkg::RING_OUT] : ring[msgq_pkg::RING_IN];

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend <= 2'b00;
		end else begin
			// A new event in the serve cycle stays pending
			pend <= (pend & ~serve) |
				(RING_EVENT & {2{QUEUES_ON}} &
				{ring[msgq_pkg::RING_OUT].ntype != msgq_pkg::NT_NONE,
				ring[msgq_pkg::RING_IN].ntype != msgq_pkg::NT_NONE});
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.note_wr <= 1'b0;
			LINK.note_irq <= 1'b0;
			LINK.note_ring <= 1'b0;
			LINK.note_addr <= 24'h000000;
			LINK.note_am <= 6'h00;
			LINK.note_data <= 8'h00;
			LINK.note_vec <= 16'h0000;
		end else begin
			LINK.note_wr <= (serve != 2'b00) && (sr.ntype == msgq_pkg::NT_MEMWR);
			LINK.note_irq <= (serve != 2'b00) && (sr.ntype == msgq_pkg::NT_VECT);
			if (serve != 2'b00) begin
				LINK.note_ring <= serve[msgq_pkg::RING_OUT];
				LINK.note_addr <= sr.naddr[23:0];
				LINK.note_am <= sr.naddr[msgq_pkg::AM_LSB +: msgq_pkg::AM_W];
				LINK.note_data <= sr.nval;
				LINK.note_vec <= sr.naddr[31:16];
			end
		end
	end

	// Addresses are 24-bit: ring base[23:0] plus a 16-bit offset that wraps, but the sum can carry out of the segment
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			INBOUND_HDR_ADDR <= 24'h000000;
			OUTBOUND_HDR_ADDR <= 24'h000000;
			BUF_LINK_ADDR <= 24'h000000;
			BUF_STATUS_ADDR <= 24'h000000;
			BUF_LEN_ADDR <= 24'h000000;
			BUF_DATA_ADDR <= 24'h000000;
			BUF_DEV_OWNED <= 1'b0;
		end else begin
			INBOUND_HDR_ADDR <= msgq_pkg::ring_addr(ring[msgq_pkg::RING_IN].base,
				ring[msgq_pkg::RING_IN].hdr);
			OUTBOUND_HDR_ADDR <= msgq_pkg::ring_addr(ring[msgq_pkg::RING_OUT].base,
				ring[msgq_pkg::RING_OUT].hdr);
			BUF_LINK_ADDR <= msgq_pkg::ring_addr(ring[BUF_RING].base,
				BUF_OFF + msgq_pkg::BUF_LINK_OFF);
			BUF_STATUS_ADDR <= msgq_pkg::ring_addr(ring[BUF_RING].base,
				BUF_OFF + msgq_pkg::BUF_STAT_OFF);
			BUF_LEN_ADDR <= msgq_pkg::ring_addr(ring[BUF_RING].base,
				BUF_OFF + msgq_pkg::BUF_LEN_OFF);
			BUF_DATA_ADDR <= msgq_pkg::ring_addr(ring[BUF_RING].base,
				BUF_OFF + msgq_pkg::BUF_DATA_OFF);
			BUF_DEV_OWNED <= BUF_STATUS_BYTE[msgq_pkg::STAT_OWNER_BIT];
		end
	end
endmodule : msgq_dev_end

/* File: hw/msgq_host_end.sv */
// Host end: software builds the config request in AHB-Lite registers,
// starts it, and reads back the reply code, the reply and ring notices.
// Assumes the board end answers on the link with a one-cycle rsp_valid.
`timescale 1ns/1ps
module msgq_host_end (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	cfg_link_if.host LINK
);
	logic [31:0] regs [0:8];
	logic [7:0] ph_addr;
	logic ph_wr;
	logic ph_rd;
	logic busy;
	logic done;
	logic [7:0] code;
	logic [31:0] rplace;
	logic [31:0] rcounts;
	logic [3:0] events;
	logic [15:0] last_val;
	logic take;
	logic go;
	logic link_mode;
	logic [31:0] rmux;

	assign take = HSEL && HTRANS[1] && HREADY;
	assign HREADYOUT = !ph_rd;
	assign HRESP = 1'b0;
	assign go = ph_wr && ph_addr == msgq_pkg::REG_CTRL && HWDATA[0] && !busy;
	// Mode comes from the go write itself; the CTRL register lands on that same edge
	assign link_mode = HWDATA[15:8] == msgq_pkg::MODE_LINK;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_addr <= 8'h00;
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
		end else begin
			ph_rd <= take && !HWRITE;
			ph_wr <= take && HWRITE;
			if (take) begin
				ph_addr <= {HADDR[7:2], 2'b00};
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 9; i++) begin
				regs[i] <= 32'h0000_0000;
			end
		end else if (ph_wr && ph_addr <= msgq_pkg::REG_OUT_NADDR) begin
			regs[ph_addr[5:2]] <= HWDATA;
		end
	end

	always_comb begin
		rmux = 32'h0000_0000;
		if (ph_addr <= msgq_pkg::REG_OUT_NADDR) begin
			rmux = regs[ph_addr[5:2]];
		end else if (ph_addr == msgq_pkg::REG_STATUS) begin
			rmux = {16'h0000, code, 6'h00, done, busy};
		end else if (ph_addr == msgq_pkg::REG_RPLACE) begin
			rmux = rplace;
		end else if (ph_addr == msgq_pkg::REG_RCOUNTS) begin
			rmux = rcounts;
		end else if (ph_addr == msgq_pkg::REG_EVENTS) begin
			rmux = {last_val, 12'h000, events};
		end
	end

	// One wait state so read data always comes from a flip-flop
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (ph_rd) begin
			HRDATA <= rmux;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LINK.req_valid <= 1'b0;
			LINK.req <= '0;
		end else begin
			LINK.req_valid <= go;
			if (go) begin
				LINK.req.mode <= HWDATA[15:8];
				LINK.req.place <= link_mode ? msgq_pkg::KEEP_PLACE : regs[1];
				LINK.req.procs <= link_mode ? msgq_pkg::KEEP8 : regs[2][7:0];
				LINK.req.mboxes <= link_mode ? msgq_pkg::KEEP8 : regs[2][15:8];
				LINK.req.slots <= regs[2][23:16];
				LINK.req.hosts <= regs[2][31:24];
				for (int r = 0; r < 2; r++) begin
					LINK.req.ring[r].base <= regs[3 + 3 * r] &
						~(msgq_pkg::BASE_RSV_MASK | msgq_pkg::BASE_ALIGN_MASK);
					LINK.req.ring[r].hdr <= regs[4 + 3 * r][15:0];
					LINK.req.ring[r].ntype <= regs[4 + 3 * r][23:16];
					LINK.req.ring[r].nval <= regs[4 + 3 * r][31:24];
					LINK.req.ring[r].naddr <= regs[5 + 3 * r];
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy <= 1'b0;
			done <= 1'b0;
			code <= msgq_pkg::RC_OK;
			rplace <= 32'h0000_0000;
			rcounts <= 32'h0000_0000;
		end else if (go) begin
			busy <= 1'b1;
			done <= 1'b0;
		end else if (LINK.rsp_valid) begin
			busy <= 1'b0;
			done <= 1'b1;
			code <= LINK.rsp_code;
			rplace <= LINK.rsp.place;
			rcounts <= {LINK.rsp.hosts, LINK.rsp.slots, LINK.rsp.mboxes, LINK.rsp.procs};
		end
	end

	// Sticky notice flags, write one to clear; a new notice beats the clear
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			events <= 4'h0;
			last_val <= 16'h0000;
		end else begin
			events <= (events & ~((ph_wr && ph_addr == msgq_pkg::REG_EVENTS) ? HWDATA[3:0] : 4'h0))
				| {LINK.note_irq & LINK.note_ring, LINK.note_wr & LINK.note_ring,
				LINK.note_irq & ~LINK.note_ring, LINK.note_wr & ~LINK.note_ring};
			if (LINK.note_irq) begin
				last_val <= LINK.note_vec;
			end else if (LINK.note_wr) begin
				last_val <= {8'h00, LINK.note_data};
			end
		end
	end
endmodule : msgq_host_end

/* File: bench/msgq_link_assertions.sv */
// Checker for the configuration link between the board end and the host end.
// Assumes one clock and the async active-low reset of the board.
`timescale 1ns/1ps
module msgq_link_assertions (
	input logic CORE_CLK,
	input logic RST_N,
	input logic req_valid,
	input msgq_pkg::cfg_msg_t req,
	input logic rsp_valid,
	input logic [7:0] rsp_code,
	input msgq_pkg::cfg_msg_t rsp,
	input logic note_wr,
	input logic note_irq,
	input logic note_ring,
	input logic [23:0] note_addr,
	input logic [5:0] note_am,
	input logic [7:0] note_data,
	input logic [15:0] note_vec
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	logic ok;
	assign ok = rsp_valid && rsp_code == msgq_pkg::RC_OK;

	property p_rsp_follows; req_valid |=> rsp_valid; endproperty
	a_rsp_follows: assert property (p_rsp_follows) else $error("reply missing");
	property p_rsp_cause; rsp_valid |-> $past(req_valid); endproperty
	a_rsp_cause: assert property (p_rsp_cause) else $error("reply without request");
	property p_ring_echo; ok && $past(req.hosts) == 8'h01 |-> rsp.ring == $past(req.ring);
	endproperty
	a_ring_echo: assert property (p_ring_echo) else $error("ring fields not echoed");
	property p_mode_code; rsp_valid && $past(req.mode) > 8'h02 |-> rsp_code == 8'hA7;
	endproperty
	a_mode_code: assert property (p_mode_code) else $error("reserved mode accepted");
	property p_procs_rng; ok && $past(req.mode) != 8'h00 |-> rsp.procs inside {[1:128]};
	endproperty
	a_procs_rng: assert property (p_procs_rng) else $error("process count out of range");
	property p_slots_rng; ok |-> rsp.slots <= 8'hFC; endproperty
	a_slots_rng: assert property (p_slots_rng) else $error("slot count out of range");
	property p_host_echo; ok |-> rsp.hosts == $past(req.hosts); endproperty
	a_host_echo: assert property (p_host_echo) else $error("host count not echoed");
	property p_ntype_ok; ok && $past(req.hosts) == 8'h01 |->
		rsp.ring[0].ntype inside {8'h00, 8'h02, 8'h04} && rsp.ring[1].ntype inside {8'h00, 8'h02, 8'h04};
	endproperty
	a_ntype_ok: assert property (p_ntype_ok) else $error("undefined notice type accepted");
	property p_memwr; note_wr |-> note_data == rsp.ring[note_ring].nval &&
		note_addr == rsp.ring[note_ring].naddr[23:0] && note_am == rsp.ring[note_ring].naddr[29:24];
	endproperty
	a_memwr: assert property (p_memwr) else $error("memory write notice fields wrong");
	property p_vector; note_irq |-> note_vec == rsp.ring[note_ring].naddr[31:16] && !note_wr;
	endproperty
	a_vector: assert property (p_vector) else $error("vector notice wrong");
endmodule : msgq_link_assertions

/* File: bench/host_config_and_msg_queue_test.sv */
// Bench: software writes the config over AHB-Lite, board end answers on the link.
// Assumes both ends run on one 40 MHz clock; the checker watches the link.
`timescale 1ns/1ps
module host_config_and_msg_queue_test;
	localparam logic [31:0] KP = 32'hFFFF_FFFF;
	localparam logic [31:0] CNT = 32'h01FC_8014;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] ring_event = 2'b00;
	logic buf_ring = 1'b0;
	logic [15:0] buf_off = 16'h0;
	logic [7:0] buf_stat = 8'h00;
	logic hready, hresp, configured, queues_on, owned;
	logic [31:0] hrdata, data_place, rd;
	logic [7:0] cur_mode, cur_procs, cur_mboxes, cur_slots, cur_hosts;
	logic [23:0] in_hdr, out_hdr, link_a, stat_a, len_a, data_a;
	int n_errors = 0;
	int checks_done = 0;
	cfg_link_if link();

	always #12.5 core_clk = ~core_clk;

	msgq_host_end u_msgq_host_end (.CORE_CLK(core_clk), .RST_N(rst_n), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .LINK(link));
	msgq_dev_end u_msgq_dev_end (.CORE_CLK(core_clk), .RST_N(rst_n), .LINK(link),
		.RING_EVENT(ring_event), .BUF_RING(buf_ring), .BUF_OFF(buf_off),
		.BUF_STATUS_BYTE(buf_stat), .CONFIGURED(configured), .QUEUES_ON(queues_on),
		.CUR_MODE(cur_mode), .DATA_PLACE(data_place), .CUR_PROCS(cur_procs),
		.CUR_MBOXES(cur_mboxes), .CUR_SLOTS(cur_slots), .CUR_HOSTS(cur_hosts),
		.INBOUND_HDR_ADDR(in_hdr), .OUTBOUND_HDR_ADDR(out_hdr), .BUF_LINK_ADDR(link_a),
		.BUF_STATUS_ADDR(stat_a), .BUF_LEN_ADDR(len_a), .BUF_DATA_ADDR(data_a),
		.BUF_DEV_OWNED(owned));
	msgq_link_assertions u_msgq_link_assertions (.CORE_CLK(core_clk), .RST_N(rst_n),
		.req_valid(link.req_valid), .req(link.req), .rsp_valid(link.rsp_valid),
		.rsp_code(link.rsp_code), .rsp(link.rsp), .note_wr(link.note_wr),
		.note_irq(link.note_irq), .note_ring(link.note_ring), .note_addr(link.note_addr),
		.note_am(link.note_am), .note_data(link.note_data), .note_vec(link.note_vec));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish();
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// Called just after a rising edge; returns at the edge that ends the data phase
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task run_cfg(input logic [7:0] mode, input logic [31:0] place, input logic [31:0] cnt,
		input logic [7:0] nt, input logic [7:0] code);
		ahb(1'b1, msgq_pkg::REG_PLACE, place);
		ahb(1'b1, msgq_pkg::REG_COUNTS, cnt);
		ahb(1'b1, msgq_pkg::REG_IN_BASE, 32'h3D0E_2000);
		ahb(1'b1, msgq_pkg::REG_IN_NOTE, {8'h40, nt, 16'h0100});
		ahb(1'b1, msgq_pkg::REG_IN_NADDR, 32'h3D0E_2044);
		ahb(1'b1, msgq_pkg::REG_OUT_BASE, 32'h3D0F_0000);
		ahb(1'b1, msgq_pkg::REG_OUT_NOTE, 32'h5504_0200);
		ahb(1'b1, msgq_pkg::REG_OUT_NADDR, 32'h0077_0000);
		ahb(1'b1, msgq_pkg::REG_CTRL, {16'h0, mode, 8'h01});
		repeat (3) @(posedge core_clk);
		ahb(1'b0, msgq_pkg::REG_STATUS, 32'h0);
		check({16'h0, rd[15:8], 6'h0, rd[1:0]}, {16'h0, code, 8'h02});
	endtask : run_cfg

	// Clears the sticky event bits first so each read shows only this pulse
	task pulse(input logic [1:0] ev);
		ahb(1'b1, msgq_pkg::REG_EVENTS, 32'h0000_000F);
		ring_event <= ev;
		@(posedge core_clk);
		ring_event <= 2'b00;
		repeat (4) @(posedge core_clk);
		ahb(1'b0, msgq_pkg::REG_EVENTS, 32'h0);
	endtask : pulse

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check({cur_procs, cur_mboxes, cur_slots, cur_hosts}, 32'h0C10_0800);
		check(data_place, 32'h0000_2000);
		check({30'h0, configured, hresp}, 32'h0000_0000);
		run_cfg(8'h01, KP, CNT, 8'h02, 8'h00);
		check({30'h0, configured, hresp}, 32'h0000_0002);
		ahb(1'b0, msgq_pkg::REG_RPLACE, 32'h0);
		check(rd, 32'h0000_2000);
		ahb(1'b0, msgq_pkg::REG_RCOUNTS, 32'h0);
		check(rd, CNT);
		check({in_hdr, 7'h0, queues_on}, 32'h0E21_0001);
		check({8'h0, out_hdr}, 32'h000F_0200);
		buf_stat <= 8'h03;
		buf_off <= 16'h0010;
		repeat (2) @(posedge core_clk);
		check({stat_a, 7'h0, owned}, 32'h0E20_1301);
		check({8'h0, data_a}, 32'h000E_2016);
		buf_ring <= 1'b1;
		buf_off <= 16'hFFFE;
		buf_stat <= 8'h02;
		repeat (2) @(posedge core_clk);
		check({link_a, 7'h0, owned}, 32'h0FFF_FE00);
		check({8'h0, len_a}, 32'h000F_0002);
		check({8'h0, data_a}, 32'h000F_0004);
		pulse(2'b11);
		check(rd, 32'h0077_0009);
		run_cfg(8'h03, KP, CNT, 8'h02, 8'hA7);
		run_cfg(8'h01, 32'h0001_1000, CNT, 8'h02, 8'hA8);
		run_cfg(8'h01, 32'h0000_0380, CNT, 8'h02, 8'hA8);
		run_cfg(8'h01, KP, 32'h01FC_8000, 8'h02, 8'hA9);
		run_cfg(8'h01, KP, 32'h01FC_8081, 8'h02, 8'hA9);
		run_cfg(8'h01, KP, 32'h01FC_0014, 8'h02, 8'hAA);
		run_cfg(8'h01, KP, 32'h01FD_8014, 8'h02, 8'hAB);
		run_cfg(8'h01, KP, 32'h00FC_8014, 8'h02, 8'hAC);
		run_cfg(8'h00, KP, 32'h0008_FFFF, 8'h02, 8'hAC);
		run_cfg(8'h01, KP, CNT, 8'h01, 8'hAD);
		run_cfg(8'h01, KP, CNT, 8'h03, 8'hAD);
		check({cur_procs, cur_mboxes, cur_slots, cur_hosts}, 32'h1480_FC01);
		run_cfg(8'h01, 32'h0000_0300, KP, 8'h02, 8'h00);
		ahb(1'b0, msgq_pkg::REG_RCOUNTS, 32'h0);
		check(rd, 32'hFFFC_8014);
		check(data_place, 32'h0000_0300);
		run_cfg(8'h00, KP, 32'h0108_FFFF, 8'h04, 8'h00);
		check({16'h0, cur_mode, cur_slots}, 32'h0000_0008);
		pulse(2'b01);
		check(rd, 32'h3D0E_0002);
		run_cfg(8'h01, KP, CNT, 8'h00, 8'h00);
		pulse(2'b01);
		check({28'h0, rd[3:0]}, 32'h0);
		run_cfg(8'h02, 32'h0000_FF00, 32'h0000_0101, 8'h02, 8'h00);
		check({16'h0, cur_slots, 7'h0, queues_on}, 32'h0);
		check(data_place, 32'h0000_FF00);
		pulse(2'b11);
		check({28'h0, rd[3:0]}, 32'h0);
		ahb(1'b1, 8'h3C, 32'h1234_5678);
		ahb(1'b0, 8'h3C, 32'h0);
		check(rd, 32'h0);
		tally_and_finish();
	end
endmodule : host_config_and_msg_queue_test
